// ---- core/dcipc_consts.vh ----
/*
  Constants of the dual channel indicator panel control: register offsets,
  field positions, reset values and timing figures.
  Assumes a 40 MHz system clock and a plain byte-addressed register port.
*/
`ifndef DCIPC_CONSTS_VH
`define DCIPC_CONSTS_VH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define DCIPC_CLK_HZ        40000000
`define DCIPC_SAMPLE_HZ     100
`define DCIPC_SAMPLE_CYC    (`DCIPC_CLK_HZ / `DCIPC_SAMPLE_HZ)
`define DCIPC_TARE_HOLD_MS  1000
`define DCIPC_LOCK_HOLD_MS  2000
`define DCIPC_DEBOUNCE_MS   10
`define DCIPC_CALWIN_MS     3000
`define DCIPC_BLINK_MS      250
`define DCIPC_MS_CYC(ms)    ((`DCIPC_CLK_HZ / 1000) * (ms))

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define DCIPC_REG_CTRL      8'h00
`define DCIPC_REG_STATUS    8'h04
`define DCIPC_REG_INT_STAT  8'h08
`define DCIPC_REG_INT_MASK  8'h0C
`define DCIPC_REG_RES_A     8'h10
`define DCIPC_REG_RES_B     8'h14
`define DCIPC_REG_RES_T     8'h18
`define DCIPC_REG_TARE_A    8'h1C
`define DCIPC_REG_TARE_B    8'h20

// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define DCIPC_CTRL_SUB_BIT  0
`define DCIPC_CTRL_UNIT_LO  1
`define DCIPC_CTRL_RST      4'h0
`define DCIPC_EV_W          6
`define DCIPC_EV_SAMPLE     0
`define DCIPC_EV_TARE_SET   1
`define DCIPC_EV_TARE_CLR   2
`define DCIPC_EV_MODE       3
`define DCIPC_EV_LOCK       4
`define DCIPC_EV_REFUSE     5

// ----------------------------------------------------------------
// Modes and keys
// ----------------------------------------------------------------
`define DCIPC_M_MEAS        2'h0
`define DCIPC_M_SETT        2'h1
`define DCIPC_M_CALSEL      2'h2
`define DCIPC_K_MENU        0
`define DCIPC_K_TARE_A      1
`define DCIPC_K_TARE_B      2
`define DCIPC_K_CAN_A       3
`define DCIPC_K_CAN_B       4
`define DCIPC_K_ESC         5
`define DCIPC_K_COMMIT      6
`define DCIPC_NKEYS         7

`endif

// ---- core/dcipc_panel.v ----
/*
  Front-panel control and measurement sequencing of a two-channel
  strain-gauge indicator: synchronous sampling, sum/difference, tare with
  non-volatile backing, seven keys with hold thresholds, key lock,
  calibration-lock entry, status lamps, register port and interrupt.
  Assumes: converter data and overload flags on this clock; keys and hold
  input are raw pins; non-volatile store presents saved tare at reset.
*/
`default_nettype none
`include "dcipc_consts.vh"

module dcipc_panel #(
  parameter DW        = 20,                                   // Sample width
  parameter SAMPLE    = `DCIPC_SAMPLE_CYC,                    // Cycles per sample
  parameter HOLD1     = `DCIPC_MS_CYC(`DCIPC_TARE_HOLD_MS),   // 1 s hold
  parameter HOLD2     = `DCIPC_MS_CYC(`DCIPC_LOCK_HOLD_MS),   // 2 s hold
  parameter DEBOUNCE  = `DCIPC_MS_CYC(`DCIPC_DEBOUNCE_MS),    // Debounce time
  parameter CALWIN    = `DCIPC_MS_CYC(`DCIPC_CALWIN_MS),      // Power-on window
  parameter BLINK     = `DCIPC_MS_CYC(`DCIPC_BLINK_MS)        // Half blink period
) (
  input  wire          mclk_i,          // System clock
  input  wire          arst_n_i,        // Async reset, active low
  input  wire [7:0]    addr_i,          // Register byte address
  input  wire [31:0]   wr_data_i,       // Write data
  input  wire          wr_i,            // Write strobe
  input  wire          rd_i,            // Read strobe
  output reg  [31:0]   rd_data_o,       // Read data, cycle after strobe
  output wire          irq_o,           // Level interrupt
  input  wire [6:0]    keys_i,          // Raw key pins, high pressed
  input  wire          hold_in_i,       // Raw external hold input
  output reg           conv_start_o,    // Converter start pulse
  input  wire [DW-1:0] first_input_channel_i,  // Channel A converter word
  input  wire [DW-1:0] second_input_channel_i, // Channel B converter word
  input  wire [1:0]    overload_i,      // Overload per channel
  input  wire [7:0]    cmp_hit_i,       // Comparator judgements
  output wire [7:0]    cmp_oc_o,        // Open-collector out, always low level
  output wire [7:0]    cmp_oc_oe_o,     // Open-collector enable
  output wire [7:0]    comparator_lamps_o, // Comparator lamps
  output wire [1:0]    tare_lamp_o,     // Tare lamps A,B
  output reg           hold_lamp_o,     // Hold lamp
  output wire [2:0]    unit_o,          // Unit indication
  output wire [1:0]    mode_o,          // Operating mode
  output wire          key_locked_o,    // Key lock state
  output wire          cal_lock_o,      // Calibration lock state
  output reg           locked_msg_o,    // Show locked message pulse
  output reg  [5:0]    nav_o,           // Settings navigation pulses
  output reg           commit_o,        // Commit setting pulse
  output reg           leave_o,         // Leave settings pulse
  input  wire [DW-1:0] nv_tare_a_i,     // Stored tare A
  input  wire [DW-1:0] nv_tare_b_i,     // Stored tare B
  input  wire [1:0]    nv_on_i,         // Stored tare enables
  output reg           nv_we_o,         // Non-volatile write pulse
  output reg  [DW-1:0] nv_tare_a_o,     // Tare A to store
  output reg  [DW-1:0] nv_tare_b_o,     // Tare B to store
  output reg  [1:0]    nv_on_o          // Tare enables to store
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  reg  [6:0]    k_s1;                   // Key sync stage 1
  reg  [6:0]    k_s2;                   // Key sync stage 2
  reg  [6:0]    k_lvl;                  // Debounced key level
  reg  [6:0]    press_p;                // Debounced press pulse
  reg  [6:0]    hold_p;                 // Hold threshold pulse
  reg  [6:0]    hold_done;              // Hold already fired this press
  reg  [31:0]   dbc [0:6];              // Debounce counters
  reg  [31:0]   hcnt [0:6];             // Hold counters
  reg  [1:0]    h_s;                    // Hold input sync
  reg  [31:0]   smp_cnt;                // Sample divider
  reg  [31:0]   blk_cnt;                // Blink divider
  reg  [31:0]   win_cnt;                // Power-on window counter
  reg  [1:0]    esc_cnt;                // Escapes within window
  reg           loaded;                 // Stored tare loaded
  reg  [1:0]    mode;                   // Operating mode
  reg           klock;                  // Key lock
  reg           cal_lock;               // Calibration lock
  reg           cal_cand;               // Calibration candidate
  reg  [3:0]    ctrl;                   // Control register
  reg  [5:0]    int_stat;               // Sticky events
  reg  [5:0]    int_mask;               // Event mask
  reg  [5:0]    ev;                     // Event pulses
  reg  [1:0]    tare_on;                // Tare subtraction active
  reg  [DW-1:0] tare_a;                 // Tare offset A
  reg  [DW-1:0] tare_b;                 // Tare offset B
  reg  [DW-1:0] raw_a;                  // Latest raw A
  reg  [DW-1:0] raw_b;                  // Latest raw B
  reg  [DW-1:0] res_a;                  // Net A
  reg  [DW-1:0] res_b;                  // Net B
  reg  [DW-1:0] res_t;                  // Combined result
  reg           smp_d;                  // Sample taken last cycle
  wire          tick;                   // Sample instant
  wire          in_win;                 // Inside power-on window
  wire [DW-1:0] net_a;                  // Net A combinational
  wire [DW-1:0] net_b;                  // Net B combinational
  genvar        gi;

  // ----------------------------------------------------------------
  // Key synchronise, debounce and hold timing
  // ----------------------------------------------------------------
  // Two flops per pin before any logic looks at it
  always @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      k_s1 <= 7'h00;
      k_s2 <= 7'h00;
      h_s  <= 2'h0;
    end else begin
      k_s1 <= keys_i;
      k_s2 <= k_s1;
      h_s  <= {h_s[0], hold_in_i};
    end
  end

  generate
    for (gi = 0; gi < `DCIPC_NKEYS; gi = gi + 1) begin : g_key
      // Level accepted after it stays put for the debounce time
      always @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
          dbc[gi]       <= 32'h0;
          hcnt[gi]      <= 32'h0;
          k_lvl[gi]     <= 1'b0;
          press_p[gi]   <= 1'b0;
          hold_p[gi]    <= 1'b0;
          hold_done[gi] <= 1'b0;
        end else begin
          press_p[gi] <= 1'b0;
          hold_p[gi]  <= 1'b0;
          if (k_s2[gi] == k_lvl[gi]) begin
            dbc[gi] <= 32'h0;
          end else if (dbc[gi] >= DEBOUNCE - 1) begin
            dbc[gi]     <= 32'h0;
            k_lvl[gi]   <= k_s2[gi];
            press_p[gi] <= k_s2[gi];
          end else begin
            dbc[gi] <= dbc[gi] + 32'h1;
          end
          // Hold time counts from the debounced press only
          if (!k_lvl[gi]) begin
            hcnt[gi]      <= 32'h0;
            hold_done[gi] <= 1'b0;
          end else if (!hold_done[gi]) begin
            if (hcnt[gi] >= ((gi == `DCIPC_K_ESC) ? HOLD2 : HOLD1) - 1) begin
              hold_p[gi]    <= 1'b1;
              hold_done[gi] <= 1'b1;
            end else begin
              hcnt[gi] <= hcnt[gi] + 32'h1;
            end
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Sampling and arithmetic
  // ----------------------------------------------------------------
  assign tick   = (smp_cnt == SAMPLE - 1);
  assign net_a  = tare_on[0] ? raw_a - tare_a : raw_a;
  assign net_b  = tare_on[1] ? raw_b - tare_b : raw_b;
  assign in_win = (win_cnt < CALWIN);

  // Both channels latched on one instant at the sample rate
  always @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      smp_cnt      <= 32'h0;
      conv_start_o <= 1'b0;
      raw_a        <= {DW{1'b0}};
      raw_b        <= {DW{1'b0}};
      res_a        <= {DW{1'b0}};
      res_b        <= {DW{1'b0}};
      res_t        <= {DW{1'b0}};
      smp_d        <= 1'b0;
    end else begin
      smp_cnt      <= tick ? 32'h0 : smp_cnt + 32'h1;
      conv_start_o <= tick;
      smp_d        <= tick;
      if (tick) begin
        raw_a <= first_input_channel_i;
        raw_b <= second_input_channel_i;
      end
      // Net and combined values formed together
      if (smp_d) begin
        res_a <= net_a;
        res_b <= net_b;
        res_t <= ctrl[`DCIPC_CTRL_SUB_BIT] ? net_a - net_b : net_a + net_b;
      end
    end
  end

  // ----------------------------------------------------------------
  // Lamps and pins
  // ----------------------------------------------------------------
  assign cmp_oc_o           = 8'h00;         // Transistor pulls low
  assign cmp_oc_oe_o        = cmp_hit_i;
  assign comparator_lamps_o = cmp_hit_i;
  assign tare_lamp_o        = tare_on;
  assign unit_o             = ctrl[3:1];     // Indication only, no scaling
  assign mode_o             = mode;
  assign key_locked_o       = klock;
  assign cal_lock_o         = cal_lock;

  // Hold lamp toggles while hold input is active
  always @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      blk_cnt     <= 32'h0;
      hold_lamp_o <= 1'b0;
    end else if (!h_s[1]) begin
      blk_cnt     <= 32'h0;
      hold_lamp_o <= 1'b0;
    end else if (blk_cnt >= BLINK - 1) begin
      blk_cnt     <= 32'h0;
      hold_lamp_o <= ~hold_lamp_o;
    end else begin
      blk_cnt <= blk_cnt + 32'h1;
    end
  end

  // ----------------------------------------------------------------
  // Mode, key actions, tare and storage
  // ----------------------------------------------------------------
  always @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mode         <= `DCIPC_M_MEAS;
      klock        <= 1'b0;
      cal_lock     <= 1'b1;
      cal_cand     <= 1'b1;
      win_cnt      <= 32'h0;
      esc_cnt      <= 2'h0;
      loaded       <= 1'b0;
      tare_on      <= 2'h0;
      tare_a       <= {DW{1'b0}};
      tare_b       <= {DW{1'b0}};
      ev           <= 6'h00;
      locked_msg_o <= 1'b0;
      nav_o        <= 6'h00;
      commit_o     <= 1'b0;
      leave_o      <= 1'b0;
      nv_we_o      <= 1'b0;
      nv_tare_a_o  <= {DW{1'b0}};
      nv_tare_b_o  <= {DW{1'b0}};
      nv_on_o      <= 2'h0;
    end else begin
      ev           <= {5'h00, smp_d};
      locked_msg_o <= 1'b0;
      nav_o        <= 6'h00;
      commit_o     <= 1'b0;
      leave_o      <= 1'b0;
      nv_we_o      <= 1'b0;
      if (in_win) begin
        win_cnt <= win_cnt + 32'h1;
      end
      if (!loaded) begin
        // Stored tare taken up once after reset release
        loaded  <= 1'b1;
        tare_a  <= nv_tare_a_i;
        tare_b  <= nv_tare_b_i;
        tare_on <= nv_on_i;
      end else begin
        case (mode)
          `DCIPC_M_MEAS: begin
            if (in_win && press_p[`DCIPC_K_ESC]) begin
              // Third escape inside the window opens cal-lock choice
              esc_cnt <= esc_cnt + 2'h1;
              if (esc_cnt == 2'h2) begin
                mode     <= `DCIPC_M_CALSEL;
                cal_cand <= cal_lock;
              end
            end
            if (hold_p[`DCIPC_K_ESC]) begin
              klock     <= ~klock;
              ev[`DCIPC_EV_LOCK] <= 1'b1;
            end
            if (klock) begin
              locked_msg_o <= |(press_p & 7'h5F);
            end else begin
              if (hold_p[`DCIPC_K_MENU]) begin
                mode <= `DCIPC_M_SETT;
                ev[`DCIPC_EV_MODE] <= 1'b1;
              end
              if (hold_p[`DCIPC_K_TARE_A]) begin
                if (overload_i[0]) begin
                  ev[`DCIPC_EV_REFUSE] <= 1'b1;
                end else begin
                  tare_a     <= raw_a;
                  tare_on[0] <= 1'b1;
                  ev[`DCIPC_EV_TARE_SET] <= 1'b1;
                end
              end
              if (hold_p[`DCIPC_K_TARE_B]) begin
                if (overload_i[1]) begin
                  ev[`DCIPC_EV_REFUSE] <= 1'b1;
                end else begin
                  tare_b     <= raw_b;
                  tare_on[1] <= 1'b1;
                  ev[`DCIPC_EV_TARE_SET] <= 1'b1;
                end
              end
              if (hold_p[`DCIPC_K_CAN_A] || hold_p[`DCIPC_K_CAN_B]) begin
                if (hold_p[`DCIPC_K_CAN_A]) tare_on[0] <= 1'b0;
                if (hold_p[`DCIPC_K_CAN_B]) tare_on[1] <= 1'b0;
                ev[`DCIPC_EV_TARE_CLR] <= 1'b1;
              end
            end
          end
          `DCIPC_M_SETT: begin
            // Settings key ignored here
            nav_o[1:0] <= {press_p[`DCIPC_K_TARE_B], press_p[`DCIPC_K_TARE_A]};
            nav_o[3:2] <= {press_p[`DCIPC_K_CAN_B], press_p[`DCIPC_K_CAN_A]};
            commit_o   <= press_p[`DCIPC_K_COMMIT];
            if (press_p[`DCIPC_K_ESC]) begin
              leave_o <= 1'b1;
              mode    <= `DCIPC_M_MEAS;
              ev[`DCIPC_EV_MODE] <= 1'b1;
            end
          end
          `DCIPC_M_CALSEL: begin
            if (press_p[`DCIPC_K_TARE_A] || press_p[`DCIPC_K_TARE_B]) begin
              cal_cand <= ~cal_cand;
            end
            if (press_p[`DCIPC_K_COMMIT]) begin
              cal_lock <= cal_cand;
              mode     <= `DCIPC_M_MEAS;
              ev[`DCIPC_EV_MODE] <= 1'b1;
            end
          end
          default: begin
            mode <= `DCIPC_M_MEAS;
          end
        endcase
      end
      // Any tare change is written through to storage
      if (ev[`DCIPC_EV_TARE_SET] || ev[`DCIPC_EV_TARE_CLR]) begin
        nv_we_o     <= 1'b1;
        nv_tare_a_o <= tare_a;
        nv_tare_b_o <= tare_b;
        nv_on_o     <= tare_on;
      end
    end
  end

  // ----------------------------------------------------------------
  // Register port and interrupt
  // ----------------------------------------------------------------
  assign irq_o = |(int_stat & int_mask);

  // Writes, sticky status; a new event beats a clear in the same cycle
  always @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctrl     <= `DCIPC_CTRL_RST;
      int_stat <= 6'h00;
      int_mask <= 6'h00;
    end else begin
      if (wr_i && addr_i == `DCIPC_REG_CTRL) ctrl <= wr_data_i[3:0];
      if (wr_i && addr_i == `DCIPC_REG_INT_MASK) int_mask <= wr_data_i[5:0];
      if (wr_i && addr_i == `DCIPC_REG_INT_STAT) begin
        int_stat <= (int_stat & ~wr_data_i[5:0]) | ev;
      end else begin
        int_stat <= int_stat | ev;
      end
    end
  end

  // Read data one cycle after the strobe, zero otherwise
  always @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rd_data_o <= 32'h0;
    end else if (!rd_i) begin
      rd_data_o <= 32'h0;
    end else begin
      case (addr_i)
        `DCIPC_REG_CTRL:     rd_data_o <= {28'h0, ctrl};
        `DCIPC_REG_STATUS:   rd_data_o <= {25'h0, h_s[1], cal_lock, klock, tare_on, mode};
        `DCIPC_REG_INT_STAT: rd_data_o <= {26'h0, int_stat};
        `DCIPC_REG_INT_MASK: rd_data_o <= {26'h0, int_mask};
        `DCIPC_REG_RES_A:    rd_data_o <= {{(32-DW){res_a[DW-1]}}, res_a};
        `DCIPC_REG_RES_B:    rd_data_o <= {{(32-DW){res_b[DW-1]}}, res_b};
        `DCIPC_REG_RES_T:    rd_data_o <= {{(32-DW){res_t[DW-1]}}, res_t};
        `DCIPC_REG_TARE_A:   rd_data_o <= {{(32-DW){tare_a[DW-1]}}, tare_a};
        `DCIPC_REG_TARE_B:   rd_data_o <= {{(32-DW){tare_b[DW-1]}}, tare_b};
        default:             rd_data_o <= 32'h0;
      endcase
    end
  end

endmodule // dcipc_panel
`default_nettype wire

// ---- tb/dcipc_panel_asserts.sv ----
/*
  Port checker for dcipc_panel, bound into every instance.
  Assumes one clock and the bench's shortened parameters.
*/
`default_nettype none
module dcipc_panel_asserts #(parameter SAMPLE = 100) (
  input wire logic       mclk_i,             // Clock
  input wire logic       arst_n_i,           // Reset, active low
  input wire logic       conv_start_o,       // Sample pulse
  input wire logic [7:0] cmp_hit_i,          // Judgements
  input wire logic [7:0] cmp_oc_o,           // Open-collector level
  input wire logic [7:0] cmp_oc_oe_o,        // Open-collector enable
  input wire logic [7:0] comparator_lamps_o, // Comparator lamps
  input wire logic       hold_lamp_o,        // Hold lamp
  input wire logic [1:0] tare_lamp_o,        // Tare lamps
  input wire logic [1:0] overload_i,         // Overload
  input wire logic       nv_we_o,            // Store pulse
  input wire logic [1:0] nv_on_o,            // Stored enables
  input wire logic       commit_o,           // Commit pulse
  input wire logic [1:0] mode_o,             // Mode
  input wire logic [5:0] nav_o,              // Navigation pulses
  input wire logic       locked_msg_o,       // Locked message
  input wire logic       key_locked_o        // Key lock
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------
  // Helper logic
  // ----------------------------------------------------------
  int unsigned cnt;  // Cycles since last sample pulse
  logic        seen; // A sample pulse was seen
  logic        rdy;  // Past the stored-tare load edge
  // Count the sample spacing
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt  <= 0;
      seen <= 1'b0;
      rdy  <= 1'b0;
    end else begin
      cnt  <= conv_start_o ? 0 : cnt + 1;
      seen <= seen | conv_start_o;
      rdy  <= 1'b1;
    end
  end
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!arst_n_i);
  // ----------------------------------------------------------
  // Properties
  // ----------------------------------------------------------
  property p_rate; seen |-> cnt < SAMPLE && (!conv_start_o || cnt == SAMPLE - 1); endproperty
  a_rate: assert property (p_rate) else $error("sample spacing wrong");
  property p_oc; cmp_oc_oe_o == cmp_hit_i && cmp_oc_o == 8'h00; endproperty
  a_oc: assert property (p_oc) else $error("comparator pin wrong");
  property p_lamp; comparator_lamps_o == cmp_hit_i; endproperty
  a_lamp: assert property (p_lamp) else $error("comparator lamp wrong");
  property p_blink; $rose(hold_lamp_o) |-> ##[1:8] !hold_lamp_o; endproperty
  a_blink: assert property (p_blink) else $error("hold lamp steady");
  property p_tare; rdy && $rose(tare_lamp_o[0]) |-> !$past(overload_i[0]) ##1 nv_we_o && nv_on_o[0]; endproperty
  a_tare: assert property (p_tare) else $error("tare capture wrong");
  property p_nv; nv_we_o |-> nv_on_o == tare_lamp_o; endproperty
  a_nv: assert property (p_nv) else $error("stored enables wrong");
  property p_commit; commit_o |-> $past(mode_o) != 2'h0; endproperty
  a_commit: assert property (p_commit) else $error("commit while measuring");
  property p_nav; nav_o != 6'h00 |-> $past(mode_o) != 2'h0 && nav_o[5:4] == 2'h0; endproperty
  a_nav: assert property (p_nav) else $error("navigation while measuring");
  property p_lockmsg; locked_msg_o |-> $past(key_locked_o) && $past(mode_o) == 2'h0; endproperty
  a_lockmsg: assert property (p_lockmsg) else $error("locked message unlocked");
  c_tare: cover property (rdy && $rose(tare_lamp_o[0]));
  c_sett: cover property (mode_o == 2'h1);
  c_lock: cover property (locked_msg_o);
endmodule // dcipc_panel_asserts
bind dcipc_panel dcipc_panel_asserts #(.SAMPLE(SAMPLE)) i_chk (.mclk_i(mclk_i), .arst_n_i(arst_n_i),
  .conv_start_o(conv_start_o), .cmp_hit_i(cmp_hit_i), .cmp_oc_o(cmp_oc_o), .cmp_oc_oe_o(cmp_oc_oe_o),
  .comparator_lamps_o(comparator_lamps_o), .hold_lamp_o(hold_lamp_o), .tare_lamp_o(tare_lamp_o),
  .overload_i(overload_i), .nv_we_o(nv_we_o), .nv_on_o(nv_on_o), .commit_o(commit_o), .mode_o(mode_o),
  .nav_o(nav_o), .locked_msg_o(locked_msg_o), .key_locked_o(key_locked_o));
`default_nettype wire

// ---- tb/dcipc_operator.sv ----
/*
  Operator at the panel: presses one key at a time with contact bounce.
  Assumes keys high while pressed.
*/
`default_nettype none
module dcipc_operator (
  input  wire logic       mclk_i, // Clock
  output var  logic [6:0] keys_o  // Key pins
);
  timeunit 1ns;
  timeprecision 1ps;
  initial keys_o = 7'h00;
  // Bounce once, hold n cycles, release and rest
  task automatic press(input int k, input int n);
    @(posedge mclk_i) keys_o[k] <= 1'b1;
    @(posedge mclk_i) keys_o[k] <= 1'b0;
    @(posedge mclk_i) keys_o[k] <= 1'b1;
    repeat (n) @(posedge mclk_i);
    keys_o[k] <= 1'b0;
    repeat (20) @(posedge mclk_i);
  endtask
endmodule // dcipc_operator
`default_nettype wire

// ---- tb/tb.sv ----
/*
  Self-checking bench of dcipc_panel with an operator model.
  Assumes shortened hold, debounce and sample counts.
*/
`default_nettype none
`include "dcipc_consts.vh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_i = 0, arst_n_i = 0, wr_i = 0, rd_i = 0, hold_in_i = 0; // Clock, reset, strobes
  logic [7:0]  addr_i = 0, cmp_hit_i = 8'hA5, cmp_oc_o, cmp_oc_oe_o, comparator_lamps_o; // Bus, comparators
  logic [31:0] wr_data_i = 0, rd_data_o;                          // Bus data
  logic [19:0] ch_a = 20'd30, ch_b = 20'd12, nv_tare_a_o, nv_tare_b_o; // Channels, store
  logic [1:0]  overload_i = 0, tare_lamp_o, mode_o, nv_on_o;      // Lamps, modes
  logic [6:0]  keys_i, seen;                                      // Keys, pulses seen
  logic [5:0]  nav_o;                                             // Navigation
  logic [2:0]  unit_o;                                            // Unit
  logic irq_o, conv_start_o, hold_lamp_o, key_locked_o, cal_lock_o, locked_msg_o, commit_o, leave_o, nv_we_o;
  int num_errors = 0, tests_run = 0;                              // Counters
  always #12.5 mclk_i = ~mclk_i;
  // Sticky record of one-cycle pulses
  always @(posedge mclk_i) seen <= seen | {locked_msg_o, commit_o, leave_o, nav_o[3:0]};
  dcipc_operator i_op (.mclk_i(mclk_i), .keys_o(keys_i));
  dcipc_panel #(.SAMPLE(100), .HOLD1(50), .HOLD2(100), .DEBOUNCE(4), .CALWIN(400), .BLINK(8)) i_dut (
    .mclk_i(mclk_i), .arst_n_i(arst_n_i), .addr_i(addr_i), .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i),
    .rd_data_o(rd_data_o), .irq_o(irq_o), .keys_i(keys_i), .hold_in_i(hold_in_i), .conv_start_o(conv_start_o),
    .first_input_channel_i(ch_a), .second_input_channel_i(ch_b), .overload_i(overload_i), .cmp_hit_i(cmp_hit_i),
    .cmp_oc_o(cmp_oc_o), .cmp_oc_oe_o(cmp_oc_oe_o), .comparator_lamps_o(comparator_lamps_o),
    .tare_lamp_o(tare_lamp_o), .hold_lamp_o(hold_lamp_o), .unit_o(unit_o), .mode_o(mode_o),
    .key_locked_o(key_locked_o), .cal_lock_o(cal_lock_o), .locked_msg_o(locked_msg_o), .nav_o(nav_o),
    .commit_o(commit_o), .leave_o(leave_o), .nv_tare_a_i(20'h00000), .nv_tare_b_i(20'h00000),
    .nv_on_i(2'h2), .nv_we_o(nv_we_o), .nv_tare_a_o(nv_tare_a_o), .nv_tare_b_o(nv_tare_b_o), .nv_on_o(nv_on_o));
  // ----------------------------------------------------------
  // Bus and compare tasks
  // ----------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    addr_i <= a;
    wr_data_i <= d;
    wr_i <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
    @(negedge mclk_i);
  endtask
  // Read and compare: data stand only in the cycle after the strobe
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    @(posedge mclk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    @(negedge mclk_i);
    chk(rd_data_o, e);
  endtask
  task automatic smp;
    repeat (2) @(posedge conv_start_o);
    repeat (3) @(posedge mclk_i);
  endtask
  // ----------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------
  task automatic t_cal;
    cmp_hit_i <= 8'h3C;
    repeat (3) i_op.press(5, 10);
    chk(32'(tare_lamp_o), 32'h2);
    chk(32'(mode_o), 32'h2);
    i_op.press(2, 10);
    i_op.press(6, 10);
    chk({cal_lock_o, 29'h0, mode_o}, 32'h0);
  endtask
  task automatic t_calc;
    chk({cmp_oc_oe_o, comparator_lamps_o, cmp_oc_o}, 32'h3C3C00);
    wr(`DCIPC_REG_CTRL, 32'hB);
    smp;
    rchk(`DCIPC_REG_RES_A, 32'd30);
    rchk(`DCIPC_REG_RES_T, 32'd18);
    chk(32'(unit_o), 32'h5);
    wr(`DCIPC_REG_CTRL, 32'hA);
    ch_b <= 20'd5;
    smp;
    rchk(`DCIPC_REG_RES_T, 32'd35);
    rchk(8'h40, 32'h0);
  endtask
  task automatic t_tare;
    i_op.press(1, 70);
    chk({tare_lamp_o[0], nv_on_o[0], 10'h0, nv_tare_a_o}, {2'b11, 30'd30});
    smp;
    rchk(`DCIPC_REG_RES_A, 32'd0);
    i_op.press(3, 20);
    chk(32'(tare_lamp_o[0]), 32'h1);
    i_op.press(3, 70);
    chk(32'(tare_lamp_o[0]), 32'h0);
    overload_i <= 2'h1;
    i_op.press(1, 70);
    chk({tare_lamp_o[0], irq_o}, 32'h0);
    wr(`DCIPC_REG_INT_MASK, 32'h20);
    chk(32'(irq_o), 32'h1);
    wr(`DCIPC_REG_INT_STAT, 32'h3F);
    chk(32'(irq_o), 32'h0);
  endtask
  task automatic t_menu;
    seen = 0;
    i_op.press(6, 10);
    chk(32'(seen), 32'h0);
    repeat (2) i_op.press(0, 70);
    chk(32'(mode_o), 32'h1);
    for (int k = 1; k < 5; k++) begin
      seen = 0;
      i_op.press(k, 10);
      chk(32'(seen), 32'h1 << (k - 1));
    end
    seen = 0;
    i_op.press(6, 10);
    i_op.press(5, 10);
    chk({seen[5:4], mode_o}, 32'hC);
  endtask
  task automatic t_lock;
    logic [1:0] lv = 0;
    i_op.press(5, 130);
    seen = 0;
    i_op.press(1, 70);
    chk({key_locked_o, seen[6], tare_lamp_o[0]}, 32'h6);
    hold_in_i <= 1'b1;
    repeat (10) @(posedge mclk_i);
    repeat (40) @(negedge mclk_i) lv = lv | {hold_lamp_o, !hold_lamp_o};
    hold_in_i <= 1'b0;
    repeat (10) @(posedge mclk_i);
    chk({lv, hold_lamp_o}, 32'h6);
    i_op.press(5, 130);
    chk(32'(key_locked_o), 32'h0);
  endtask
  task automatic finish_test;
    $display("errors %0d of %0d checks", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (10) @(posedge mclk_i);
    arst_n_i <= 1'b1;
    t_cal;
    t_calc;
    t_tare;
    t_menu;
    t_lock;
    finish_test;
  end
  // Watchdog
  initial begin
    #500us;
    num_errors++;
    finish_test;
  end
endmodule // tb
`default_nettype wire
